// >>> design/audio_in_pkg.sv
// Shared constants, encodings and carrier types of the serial audio input port
package audio_in_pkg;

  // ----------------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int HALF_BCLKS = 32;
  localparam int CNT_W = 6;
  localparam int NBITS_W = 5;
  localparam int BOOT_CYCLES = 1024;
  localparam int BOOT_CNT_W = 11;
  localparam int PARAM_DEPTH = 256;
  localparam int PARAM_AW = 8;
  localparam int PARAM_W = 22;
  localparam int FIFO_DEPTH = 32;

  // Right-justified sample lengths, bit cap, counter limits and MSB delays
  localparam logic [NBITS_W-1:0] RJ_LEN_24 = 5'h18;
  localparam logic [NBITS_W-1:0] RJ_LEN_20 = 5'h14;
  localparam logic [NBITS_W-1:0] RJ_LEN_16 = 5'h10;
  localparam logic [NBITS_W-1:0] MAX_BITS = 5'h18;
  localparam logic [CNT_W-1:0] HALF_CNT = 6'h20;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  localparam logic [CNT_W-1:0] I2S_DELAY = 6'h01;
  localparam logic [CNT_W-1:0] NO_DELAY = 6'h00;

  // Boot ROM fill pattern (arbitrary neutral value)
  localparam logic [PARAM_W-1:0] ROM_SEED = 22'h00_1234;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_RJ = 2'h1,
    FMT_DSP = 2'h2,
    FMT_LJ = 2'h3
  } fmt_t;

  localparam logic [1:0] LEN_SEL_24 = 2'h0;
  localparam logic [1:0] LEN_SEL_20 = 2'h1;

  typedef struct packed {
    logic left;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

endpackage

// >>> design/stereo_serial_audio_input_port.sv
// Serial audio input port: boot sequencer, deserialiser, crossing and sample FIFO
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  // ----------------------------------------------------------------------
  // Status and handshakes
  // ----------------------------------------------------------------------
  wire fifo_empty = (wr_ptr_q == rd_ptr_q);
  wire fifo_full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire do_push = in_valid && !fifo_full && !clear;
  wire stage_free = !out_valid_q || out_ready;
  wire do_pop = stage_free && !fifo_empty && !clear;

  assign in_ready = !fifo_full && !clear;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // Storage array write
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_q[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // Registered output stage
  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else if (stage_free)
    begin
      out_valid_q <= !fifo_empty;
      if (!fifo_empty)
        out_data_q <= mem[rd_ptr_q[AW-1:0]];
    end
  end
endmodule // sample_fifo

module stereo_serial_audio_input_port #(
  parameter int BOOT_CYCLES = audio_in_pkg::BOOT_CYCLES,
  parameter int FIFO_DEPTH = audio_in_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reset_in_n,
  input wire logic [1:0] fmt_sel,
  input wire logic [1:0] len_sel,
  input wire logic [audio_in_pkg::PARAM_AW-1:0] param_rd_addr,
  output logic [audio_in_pkg::PARAM_W-1:0] param_rd_data,
  output logic boot_busy,
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sdata,
  output logic sample_valid,
  input wire logic sample_ready,
  output audio_in_pkg::sample_t sample_out,
  output logic overrun
);
  localparam int SW = $bits(audio_in_pkg::sample_t);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Right-justified sample length from the length field
  function automatic logic [audio_in_pkg::NBITS_W-1:0] rj_len(input logic [1:0] sel);
    if (sel == audio_in_pkg::LEN_SEL_24)
      return audio_in_pkg::RJ_LEN_24;
    else if (sel == audio_in_pkg::LEN_SEL_20)
      return audio_in_pkg::RJ_LEN_20;
    else
      return audio_in_pkg::RJ_LEN_16;
  endfunction

  // Boot ROM default contents
  function automatic logic [audio_in_pkg::PARAM_W-1:0] boot_rom(
    input logic [audio_in_pkg::PARAM_AW-1:0] a);
    return audio_in_pkg::ROM_SEED ^ {{(audio_in_pkg::PARAM_W-audio_in_pkg::PARAM_AW){1'b0}}, a};
  endfunction

  // ----------------------------------------------------------------------
  // Core domain: reset pin sync and boot sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_HOLD, ST_BOOT, ST_RUN} boot_state_t;

  boot_state_t state_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic [audio_in_pkg::BOOT_CNT_W-1:0] boot_cnt_q;
  logic boot_busy_q;
  logic [1:0] fmt_q;
  logic [1:0] len_q;
  logic [audio_in_pkg::PARAM_W-1:0] param_ram [audio_in_pkg::PARAM_DEPTH];
  logic [audio_in_pkg::PARAM_W-1:0] param_rd_q;

  // Reset pin passes two flops before use
  always_ff @(posedge core_clk)
  begin
    pin_s1_q <= reset_in_n;
    pin_s2_q <= pin_s1_q;
  end

  wire pin_rise = pin_s2_q && !pin_prev_q;
  wire boot_last = (boot_cnt_q == audio_in_pkg::BOOT_CNT_W'(BOOT_CYCLES - 1));
  wire run_core = (state_q == ST_RUN);
  wire [audio_in_pkg::PARAM_AW-1:0] boot_addr = boot_cnt_q[audio_in_pkg::PARAM_AW-1:0];
  wire boot_fill = (state_q == ST_BOOT) &&
                   (boot_cnt_q < audio_in_pkg::BOOT_CNT_W'(audio_in_pkg::PARAM_DEPTH));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_HOLD;
      pin_prev_q <= 1'b0;
      boot_cnt_q <= '0;
    end
    else
    begin
      pin_prev_q <= pin_s2_q;
      if (!pin_s2_q)
        state_q <= ST_HOLD;
      else
      begin
        unique case (state_q)
          ST_HOLD:
          begin
            if (pin_rise)
              state_q <= ST_BOOT;
            boot_cnt_q <= '0;
          end
          ST_BOOT:
          begin
            boot_cnt_q <= boot_cnt_q + 1'b1;
            if (boot_last)
              state_q <= ST_RUN;
          end
          ST_RUN:
            boot_cnt_q <= '0;
        endcase
      end
    end
  end

  // busy flag tells the host to keep off
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      boot_busy_q <= 1'b1;
    else
      boot_busy_q <= !(run_core || (state_q == ST_BOOT && boot_last));
  end

  // parameter RAM loaded from boot ROM
  always_ff @(posedge core_clk)
  begin
    if (boot_fill)
      param_ram[boot_addr] <= boot_rom(boot_addr);
  end

  // Parameter RAM read port
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      param_rd_q <= '0;
    else
      param_rd_q <= param_ram[param_rd_addr];
  end

  // format register, I2S and 24 bits after reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      fmt_q <= audio_in_pkg::FMT_I2S;
      len_q <= audio_in_pkg::LEN_SEL_24;
    end
    else if (run_core)
    begin
      fmt_q <= fmt_sel;
      len_q <= len_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: configuration sync and deserialiser
  // ----------------------------------------------------------------------
  logic run_l1_q;
  logic run_l2_q;
  logic [3:0] cfg_l1_q;
  logic [3:0] cfg_l2_q;
  logic neg_lr_q;
  logic neg_d_q;
  logic lr_prev_q;
  logic seen_q;
  logic [audio_in_pkg::CNT_W-1:0] bit_cnt_q;
  logic [audio_in_pkg::NBITS_W-1:0] nbits_q;
  logic [audio_in_pkg::SAMPLE_W-1:0] acc_q;
  logic active_q;
  logic chan_q;
  logic dsp_left_q;
  audio_in_pkg::sample_t word_q;
  logic word_tog_q;

  // Run level and quasi-static format cross on two flops
  always_ff @(posedge bclk)
  begin
    run_l1_q <= run_core;
    run_l2_q <= run_l1_q;
    cfg_l1_q <= {fmt_q, len_q};
    cfg_l2_q <= cfg_l1_q;
  end

  always_ff @(negedge bclk)
  begin
    neg_lr_q <= lrclk;
    neg_d_q <= sdata;
  end

  wire [1:0] fmt_l = cfg_l2_q[3:2];
  wire [1:0] len_l = cfg_l2_q[1:0];
  wire is_dsp = (fmt_l == audio_in_pkg::FMT_DSP);
  wire is_rj = (fmt_l == audio_in_pkg::FMT_RJ);
  wire is_i2s = (fmt_l == audio_in_pkg::FMT_I2S);
  wire src_lr = is_dsp ? neg_lr_q : lrclk;
  wire src_d = is_dsp ? neg_d_q : sdata;
  // DSP word begins when the frame pulse ends
  wire boundary = is_dsp ? (lr_prev_q && !src_lr) : (src_lr != lr_prev_q);
  wire [audio_in_pkg::CNT_W-1:0] cnt_inc =
    (bit_cnt_q == audio_in_pkg::CNT_MAX) ? bit_cnt_q : bit_cnt_q + 1'b1;
  wire [audio_in_pkg::CNT_W-1:0] cur_cnt = boundary ? '0 : cnt_inc;
  wire [audio_in_pkg::NBITS_W-1:0] len_rj = rj_len(len_l);
  // MSB delay is half frame less the length in right-justified; one bit in I2S; none otherwise
  wire [audio_in_pkg::CNT_W-1:0] msb_delay =
    is_rj ? audio_in_pkg::HALF_CNT - {1'b0, len_rj} :
    is_i2s ? audio_in_pkg::I2S_DELAY : audio_in_pkg::NO_DELAY;
  // cap at 24 bits; right-justified uses chosen length
  wire [audio_in_pkg::NBITS_W-1:0] bit_limit = is_rj ? len_rj : audio_in_pkg::MAX_BITS;
  wire word_start = (boundary || seen_q) && (cur_cnt == msb_delay);
  wire take_bit = active_q && (nbits_q < bit_limit);
  // frame high is left; frame low is left in I2S; DSP takes the alternating left flag
  wire chan_now = is_dsp ? dsp_left_q : (is_i2s ? !src_lr : src_lr);
  // MSB-align short samples with zero fill
  wire [audio_in_pkg::NBITS_W-1:0] pad = audio_in_pkg::MAX_BITS - nbits_q;
  wire [audio_in_pkg::SAMPLE_W-1:0] aligned = acc_q << pad;

  // Bit counter and edge tracking
  always_ff @(posedge bclk)
  begin
    if (!run_l2_q)
    begin
      lr_prev_q <= src_lr; // Track idle level so enable makes no false edge
      seen_q <= 1'b0;
      bit_cnt_q <= audio_in_pkg::CNT_MAX;
    end
    else
    begin
      lr_prev_q <= src_lr;
      bit_cnt_q <= cur_cnt;
      if (boundary)
        seen_q <= 1'b1;
    end
  end

  always_ff @(posedge bclk)
  begin
    if (!run_l2_q)
    begin
      acc_q <= '0;
      nbits_q <= '0;
      active_q <= 1'b0;
      chan_q <= 1'b1;
    end
    else if (word_start)
    begin
      acc_q <= {{(audio_in_pkg::SAMPLE_W-1){1'b0}}, src_d};
      nbits_q <= 5'h01;
      active_q <= 1'b1;
      chan_q <= chan_now;
    end
    else if (take_bit)
    begin
      acc_q <= {acc_q[audio_in_pkg::SAMPLE_W-2:0], src_d};
      nbits_q <= nbits_q + 1'b1;
    end
  end

  // DSP channel alternates, left first after start
  always_ff @(posedge bclk)
  begin
    if (!run_l2_q)
      dsp_left_q <= 1'b1;
    else if (word_start && is_dsp)
      dsp_left_q <= !dsp_left_q;
  end

  // finished words leave in arrival order, left then right
  always_ff @(posedge bclk)
  begin
    if (!run_l2_q)
    begin
      word_q <= '0;
      word_tog_q <= 1'b0;
    end
    else if (word_start && active_q)
    begin
      word_q <= '{left: chan_q, data: aligned};
      word_tog_q <= !word_tog_q;
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: word crossing, holding stage and FIFO
  // ----------------------------------------------------------------------
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic pend_valid_q;
  audio_in_pkg::sample_t pend_q;
  logic overrun_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SW-1:0] fifo_out_data;

  // Toggle event passes two flops before edge detection
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else
    begin
      tog_s1_q <= word_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  wire word_arrive = (tog_s2_q != tog_s3_q) && run_core;
  wire push = pend_valid_q && fifo_in_ready;

  // Holding stage stalls while the FIFO is full
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !run_core)
    begin
      pend_valid_q <= 1'b0;
      pend_q <= '0;
      overrun_q <= 1'b0;
    end
    else
    begin
      overrun_q <= word_arrive && pend_valid_q && !push;
      if (word_arrive && (!pend_valid_q || push))
      begin
        pend_q <= word_q;
        pend_valid_q <= 1'b1;
      end
      else if (push)
        pend_valid_q <= 1'b0;
    end
  end

  sample_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(sys_rst),
    .clear(!run_core),
    .in_valid(pend_valid_q),
    .in_ready(fifo_in_ready),
    .in_data(pend_q),
    .out_valid(fifo_out_valid),
    .out_ready(sample_ready),
    .out_data(fifo_out_data)
  );

  // Outputs from flops
  assign sample_valid = fifo_out_valid;
  assign sample_out = audio_in_pkg::sample_t'(fifo_out_data);
  assign boot_busy = boot_busy_q;
  assign param_rd_data = param_rd_q;
  assign overrun = overrun_q;

endmodule // stereo_serial_audio_input_port

`default_nettype wire

// >>> tb/audio_src_model.sv
// Behavioural serial audio source: bit clock, frame clock and data
`timescale 1ns/1ps
`default_nettype none

module audio_src_model (
  output logic bclk,
  output logic lrclk,
  output logic sdata
);
  initial
  begin
    bclk = 1'b0;
    lrclk = 1'b0;
    sdata = 1'b0;
  end

  // One bit period; bit clock stands still between calls
  task automatic slot(input logic lr, input logic d);
    lrclk = lr;
    sdata = d;
    #31.3 bclk = 1'b1;
    #62.5 bclk = 1'b0;
    #31.2;
  endtask

  // Idle bits at the given frame level, random phase start
  task automatic preamble(input logic lvl);
    #($urandom_range(3, 20));
    for (int k = 0; k < 8; k++)
      slot(lvl, 1'(k));
  endtask

  task automatic half(input logic [1:0] fmt, input logic lvl, input int start,
      input int nb, input logic [31:0] v);
    logic last;
    last = sdata;
    for (int k = 0; k < 32; k++)
    begin
      if (k >= start && k < start + nb)
        last = v[31 - (k - start)];
      else if (k >= start + nb)
        last = 1'b0; // Tail is zero, as a short sample reads
      else
        last = ~last; // Lead-in slots never hold the old value
      slot((fmt == audio_in_pkg::FMT_DSP) ? (k == 0) : lvl, last);
    end
  endtask
endmodule // audio_src_model

`default_nettype wire

// >>> tb/stereo_serial_audio_input_port_assertions.sv
// Port-level assertions for the serial audio input port
`timescale 1ns/1ps
`default_nettype none

module stereo_serial_audio_input_port_assertions #(
  parameter int BOOT_CYCLES = 1024
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reset_in_n,
  input wire logic [1:0] fmt_sel,
  input wire logic [1:0] len_sel,
  input wire logic [audio_in_pkg::PARAM_AW-1:0] param_rd_addr,
  input wire logic [audio_in_pkg::PARAM_W-1:0] param_rd_data,
  input wire logic boot_busy,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire audio_in_pkg::sample_t sample_out,
  input wire logic overrun
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [11:0] pin_cnt_q;
  logic [11:0] pin_cnt_d;

  // Cycles since the reset pin went high, saturating
  assign pin_cnt_d = !reset_in_n ? 12'h0000 : (pin_cnt_q == 12'h0fff) ? pin_cnt_q :
      pin_cnt_q + 12'h0001;
  always_ff @(posedge core_clk)
    pin_cnt_q <= sys_rst ? 12'h0000 : pin_cnt_d;

  sequence s_offered;
    sample_valid && !sample_ready && reset_in_n;
  endsequence

  a_boot_min: assert property (pin_cnt_q >= 6 && pin_cnt_q < BOOT_CYCLES |-> boot_busy)
    else $error("boot ended early");
  a_boot_max: assert property (pin_cnt_q > BOOT_CYCLES + 8 |-> !boot_busy)
    else $error("boot ran too long");
  a_busy_hold: assert property (!reset_in_n [*5] |-> boot_busy)
    else $error("busy low while pin held");
  a_ram_load: assert property (!boot_busy |=> param_rd_data ==
      (audio_in_pkg::ROM_SEED ^ {14'h0000, $past(param_rd_addr)}))
    else $error("parameter word wrong");
  a_flush_out: assert property ($fell(reset_in_n) |-> ##[2:6] !sample_valid)
    else $error("output not flushed");
  a_offer_hold: assert property (s_offered |=> sample_valid && $stable(sample_out))
    else $error("offered sample changed");
  a_zero_fill: assert property (sample_valid && fmt_sel == audio_in_pkg::FMT_RJ &&
      len_sel != audio_in_pkg::LEN_SEL_24 |-> (sample_out.data &
      (len_sel[1] ? 24'h00_00ff : 24'h00_000f)) == 24'h00_0000)
    else $error("low bits not zero");
  a_overrun_pulse: assert property (overrun |=> !overrun)
    else $error("overrun longer than a cycle");
endmodule // stereo_serial_audio_input_port_assertions

bind stereo_serial_audio_input_port stereo_serial_audio_input_port_assertions #(
  .BOOT_CYCLES(BOOT_CYCLES)
) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reset_in_n(reset_in_n), .fmt_sel(fmt_sel),
  .len_sel(len_sel), .param_rd_addr(param_rd_addr), .param_rd_data(param_rd_data),
  .boot_busy(boot_busy), .sample_valid(sample_valid), .sample_ready(sample_ready),
  .sample_out(sample_out), .overrun(overrun)
);

`default_nettype wire

// >>> tb/stereo_serial_audio_input_port_test.sv
// Self-checking bench for the serial audio input port
`timescale 1ns/1ps
`default_nettype none

module stereo_serial_audio_input_port_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_in_n = 1'b0;
  logic [1:0] fmt_sel = 2'h0;
  logic [1:0] len_sel = 2'h0;
  logic [7:0] param_rd_addr = 8'h00;
  logic [21:0] param_rd_data;
  logic boot_busy;
  logic bclk;
  logic lrclk;
  logic sdata;
  logic sample_valid;
  logic sample_ready = 1'b0;
  audio_in_pkg::sample_t sample_out;
  logic overrun;
  logic hold = 1'b1;
  logic [24:0] exp_q[$];
  int n_fail = 0;
  int checks = 0;
  int n_ovr = 0;
  int cyc = 0;

  always #12.5 core_clk = ~core_clk;

  stereo_serial_audio_input_port u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reset_in_n(reset_in_n), .fmt_sel(fmt_sel),
    .len_sel(len_sel), .param_rd_addr(param_rd_addr), .param_rd_data(param_rd_data),
    .boot_busy(boot_busy), .bclk(bclk), .lrclk(lrclk), .sdata(sdata),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_out(sample_out),
    .overrun(overrun)
  );

  audio_src_model u_src (.bclk(bclk), .lrclk(lrclk), .sdata(sdata));

  // ----------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_word(input audio_in_pkg::sample_t got, input audio_in_pkg::sample_t exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected word: top bits kept up to 24, MSB-aligned, zero-filled
  function automatic logic [24:0] expect_word(input logic lft, input int nb,
      input logic [31:0] v);
    int keep;
    keep = (nb > 24) ? 24 : nb;
    return {lft, v[31:8] & (24'hff_ffff << (24 - keep))};
  endfunction

  // Consumer with random stalls, address stimulus and timeout
  always @(posedge core_clk)
  begin
    sample_ready <= hold ? 1'b0 : ($urandom_range(0, 3) != 0);
    param_rd_addr <= 8'($urandom);
    cyc++;
    if (!sys_rst && overrun)
      n_ovr++;
    if (!sys_rst && sample_valid && sample_ready)
      cmp_word(sample_out, exp_q.size() ? exp_q.pop_front() : 'x);
    if (cyc == 40000)
    begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // One reboot and a burst of frames in one format
  // ----------------------------------------------------------------------
  task automatic run(input logic [1:0] fmt, input logic [1:0] len, input int nfr,
      input logic stall);
    logic lvl;
    int nb;
    int st;
    logic [31:0] vl;
    logic [31:0] vr;
    lvl = (fmt != audio_in_pkg::FMT_I2S);
    st = (fmt == audio_in_pkg::FMT_LJ) ? 0 : 1;
    @(posedge core_clk);
    reset_in_n <= 1'b0;
    fmt_sel <= fmt;
    len_sel <= len;
    hold <= stall;
    n_ovr = 0;
    u_src.preamble(~lvl);
    @(posedge core_clk);
    reset_in_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (int k = 0; k < 1200 && boot_busy; k++)
      @(posedge core_clk);
    u_src.preamble((fmt == audio_in_pkg::FMT_DSP) ? 1'b0 : ~lvl);
    for (int f = 0; f < nfr; f++)
    begin
      nb = 16 + $urandom_range(0, 12);
      if (fmt == audio_in_pkg::FMT_RJ)
        nb = len[1] ? 16 : (len[0] ? 20 : 24);
      if (fmt == audio_in_pkg::FMT_RJ)
        st = 32 - nb;
      vl = $urandom;
      vr = $urandom;
      exp_q.push_back(expect_word(1'b1, nb, vl));
      exp_q.push_back(expect_word(1'b0, nb, vr));
      u_src.half(fmt, lvl, st, nb, vl);
      u_src.half(fmt, ~lvl, st, nb, vr);
    end
    u_src.half(fmt, lvl, st, 0, 32'h0000_0000);
    hold <= 1'b0;
    repeat (300) @(posedge core_clk);
    cmp_count(exp_q.size(), n_ovr);
  endtask

  initial
  begin
    void'($urandom(70));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int f = 0; f < 4; f++)
      run(2'(f), 2'h0, 3, 1'b0);
    for (int l = 1; l < 4; l++)
      run(audio_in_pkg::FMT_RJ, 2'(l), 3, 1'b0);
    run(audio_in_pkg::FMT_LJ, 2'h0, 20, 1'b1);
    cmp_count(int'(n_ovr > 0), 1);
    exp_q.delete();
    final_report();
  end
endmodule // stereo_serial_audio_input_port_test

`default_nettype wire
